// ---- bench/usef_far_model.sv ----
// Behavioural stand-in for the receive and transmit shifters.
`timescale 1ns/1ps
`default_nettype none
module usef_far_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic rx_halt,
    input wire usef_pkg::usef_tx_req_t tx_req,
    input wire logic rx_go,
    input wire usef_pkg::usef_rx_ev_t rx_fr,
    input wire logic rude,
    output var usef_pkg::usef_rx_ev_t rx_ev,
    output logic tx_load,
    output logic tx_last_bit,
    output logic tx_busy
);
    logic [4:0] cnt_r;

    // Fields outside a done pulse toggle so that nothing can lean on stale values.
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_ev <= '0;
        end else if (rx_go && (!rx_halt || rude)) begin
            rx_ev <= {1'b1, rx_fr[10:0]};
        end else begin
            rx_ev <= {1'b0, ~rx_ev[10:0]};
        end
    end

    // A long character time keeps the end flag low long enough to read it.
    always_ff @(posedge clk) begin
        tx_load <= 1'b0;
        tx_last_bit <= 1'b0;
        if (rst) begin
            cnt_r <= 5'h00;
            tx_busy <= 1'b0;
        end else if (cnt_r != 5'h00) begin
            cnt_r <= cnt_r - 5'h01;
            tx_last_bit <= (cnt_r == 5'h01);
            tx_busy <= (cnt_r != 5'h01);
        end else if (tx_req.data_valid && !tx_req.halt) begin
            tx_load <= 1'b1;
            tx_busy <= 1'b1;
            cnt_r <= 5'h14;
        end
    end
endmodule
`default_nettype wire

// ---- bench/usef_status_assertions.sv ----
// Port-level assertions for the serial status flag block.
`timescale 1ns/1ps
`default_nettype none
module usef_status_assertions (
    input wire logic clk,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic rx_halt,
    input wire logic tx_busy,
    input wire usef_pkg::usef_tx_req_t tx_req
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence s_wr_fire;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // With both write channels idle no flag clear can land, so a halt must persist.
    sequence s_halt_idle;
        rx_halt && !s_axi_awvalid && !s_axi_wvalid;
    endsequence
    a_reset_quiet: assert property ($fell(rst) |-> !s_axi_bvalid && !rx_halt && tx_req == '0)
        else $error("outputs not quiet after reset");
    a_wr_answer: assert property (s_wr_fire |=> s_axi_bvalid)
        else $error("write not answered");
    a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    a_wr_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered");
    a_halt_kept: assert property (s_halt_idle |=> rx_halt)
        else $error("receive halt dropped without a write");
    a_sync_halt: assert property (tx_req.halt |-> rx_halt)
        else $error("transmit halt without receive halt");
    a_mpb_idle: assert property (!tx_busy |-> !tx_req.mpb_en && !tx_req.mpb)
        else $error("multiprocessor bit active while idle");
    a_mpb_gated: assert property (tx_req.mpb |-> tx_req.mpb_en)
        else $error("multiprocessor bit without enable");
endmodule
bind usef_status usef_status_assertions usef_status_assertions_i (
    .clk(clk),
    .rst(rst),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid),
    .rx_halt(rx_halt),
    .tx_busy(tx_busy),
    .tx_req(tx_req)
);
`default_nettype wire

// ---- bench/usef_status_tb.sv ----
// Self-checking bench for the serial status flag block.
`timescale 1ns/1ps
`default_nettype none
module usef_status_tb;
    logic clk, rst, rx_go, rude, rx_halt, tx_load, tx_last_bit, tx_busy;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    usef_pkg::usef_rx_ev_t rx_ev, rx_fr;
    usef_pkg::usef_tx_req_t tx_req;
    int mismatches, checks_done;

    usef_status usef_status_i (
        .clk(clk),
        .rst(rst),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .rx_ev(rx_ev),
        .rx_halt(rx_halt),
        .tx_load(tx_load),
        .tx_last_bit(tx_last_bit),
        .tx_busy(tx_busy),
        .tx_req(tx_req)
    );
    usef_far_model usef_far_model_i (
        .clk(clk),
        .rst(rst),
        .rx_halt(rx_halt),
        .tx_req(tx_req),
        .rx_go(rx_go),
        .rx_fr(rx_fr),
        .rude(rude),
        .rx_ev(rx_ev),
        .tx_load(tx_load),
        .tx_last_bit(tx_last_bit),
        .tx_busy(tx_busy)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic hang();
        chk("timeout", 32'h1, 32'h0);
        close_out();
    endtask

    task automatic rst_dut();
        rst <= 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask

    // Readiness is sampled a quarter cycle after the edge, where it already holds the value of the coming edge.
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        logic aw, w, b;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            #5;
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge clk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (b) begin
                s_axi_bready <= 1'b0;
                @(posedge clk);
                return;
            end
        end
        hang();
    endtask

    task automatic rd(input logic [3:0] a);
        logic ar, rv;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            #5;
            ar = s_axi_arvalid && s_axi_arready;
            rv = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk);
            if (ar) s_axi_arvalid <= 1'b0;
            if (rv) begin
                s_axi_rready <= 1'b0;
                @(posedge clk);
                return;
            end
        end
        hang();
    endtask

    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        rd(a);
        chk("rdata", d, {24'h000000, e});
    endtask

    task automatic rs(input logic [7:0] e);
        rdc(usef_pkg::OFS_STATUS, e);
    endtask

    task automatic ws(input logic [7:0] v);
        wr(usef_pkg::OFS_STATUS, v);
    endtask

    task automatic snd(input logic [7:0] dat, input logic stp, par, mp, bad);
        rx_fr <= {1'b0, dat, stp, par, mp};
        rx_go <= 1'b1;
        rude <= bad;
        @(posedge clk);
        rx_go <= 1'b0;
        rude <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic waitb(input logic lvl);
        for (int n = 0; n < 99; n++) begin
            @(posedge clk);
            #5;
            if (tx_busy === lvl) begin
                @(posedge clk);
                return;
            end
        end
        hang();
    endtask

    task automatic t_regs();
        rs(8'h84);
        rd(4'h6);
        chk("resp", 32'(r), 32'(usef_pkg::RESP_SLVERR));
        wr(4'h8, 8'h00);
        chk("bresp", 32'(r), 32'(usef_pkg::RESP_SLVERR));
        s_axi_wstrb <= 4'h0;
        wr(usef_pkg::OFS_CTRL, 8'h02);
        s_axi_wstrb <= 4'h1;
        chk("bresp", 32'(r), 32'(usef_pkg::RESP_OKAY));
        rdc(usef_pkg::OFS_CTRL, 8'h00);
    endtask

    task automatic t_frame();
        rst_dut();
        wr(usef_pkg::OFS_CTRL, 8'h01);
        snd(8'h5a, 1'b0, 1'b0, 1'b0, 1'b0);
        ws(8'h00);
        rs(8'h94);
        rdc(usef_pkg::OFS_RXDATA, 8'h5a);
        snd(8'h33, 1'b1, 1'b0, 1'b0, 1'b1);
        rdc(usef_pkg::OFS_RXDATA, 8'h5a);
        wr(usef_pkg::OFS_CTRL, 8'h06);
        #5;
        chk("tx halt", 32'(tx_req.halt), 32'h1);
        chk("rx halt", 32'(rx_halt), 32'h1);
        @(posedge clk);
        wr(usef_pkg::OFS_CTRL, 8'h00);
        rs(8'h94);
        ws(8'h00);
        rs(8'h84);
    endtask

    // Both parity senses: the first character mismatches, the second is sent while halted, the third matches.
    task automatic t_parity();
        for (int o = 0; o < 2; o++) begin
            rst_dut();
            wr(usef_pkg::OFS_CTRL, (o == 1) ? 8'h19 : 8'h09);
            snd(8'h01, 1'b1, o[0], 1'b0, 1'b0);
            rs(8'h8c);
            rdc(usef_pkg::OFS_RXDATA, 8'h01);
            snd(8'h02, 1'b1, 1'b0, 1'b0, 1'b1);
            rdc(usef_pkg::OFS_RXDATA, 8'h01);
            ws(8'h00);
            rs(8'h84);
            snd(8'h03, 1'b1, o[0], 1'b0, 1'b0);
            rs(8'hc4);
        end
    endtask

    task automatic t_sync();
        rst_dut();
        wr(usef_pkg::OFS_CTRL, 8'h0d);
        snd(8'h01, 1'b0, 1'b0, 1'b0, 1'b0);
        rs(8'hc4);
        rdc(usef_pkg::OFS_RXDATA, 8'h01);
        wr(usef_pkg::OFS_CTRL, 8'h21);
        snd(8'h7e, 1'b1, 1'b0, 1'b0, 1'b0);
        rs(8'hc4);
        snd(8'h81, 1'b0, 1'b0, 1'b0, 1'b0);
        rs(8'hd4);
    endtask

    task automatic t_mpb();
        rst_dut();
        wr(usef_pkg::OFS_CTRL, 8'h41);
        snd(8'h00, 1'b1, 1'b0, 1'b1, 1'b0);
        ws(8'h00);
        rs(8'hc6);
        ws(8'h01);
        wr(usef_pkg::OFS_CTRL, 8'h42);
        wr(usef_pkg::OFS_TXDATA, 8'ha5);
        waitb(1'b1);
        chk("mpb", 32'(tx_req.mpb), 32'h1);
        waitb(1'b0);
        chk("mpb", 32'(tx_req.mpb), 32'h0);
    endtask

    task automatic t_transmit_end_flag();
        rst_dut();
        wr(usef_pkg::OFS_CTRL, 8'h02);
        rs(8'h84);
        ws(8'h80);
        rs(8'h84);
        ws(8'h00);
        rd(usef_pkg::OFS_STATUS);
        chk("transmit_end_flag", d & 32'h4, 32'h0);
        waitb(1'b0);
        repeat (2) @(posedge clk);
        rs(8'h84);
        wr(usef_pkg::OFS_TXDATA, 8'h3c);
        chk("tx data", 32'(tx_req.data), 32'h3c);
        rd(usef_pkg::OFS_STATUS);
        chk("transmit_end_flag", d & 32'h4, 32'h0);
        wr(usef_pkg::OFS_CTRL, 8'h00);
        rs(8'h84);
    endtask

    initial begin
        s_axi_awaddr = 4'h0;
        s_axi_araddr = 4'h0;
        s_axi_wdata = 32'h00000000;
        s_axi_wstrb = 4'h1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        rx_fr = '0;
        rx_go = 1'b0;
        rude = 1'b0;
        rst_dut();
        t_regs();
        t_frame();
        t_parity();
        t_sync();
        t_mpb();
        t_transmit_end_flag();
        close_out();
    end
endmodule
`default_nettype wire

// ---- hw/usef_status.sv ----
// Serial status flags with an AXI4-Lite register slave.
//
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module usef_status (
    input wire logic clk,
    input wire logic rst,
    input wire logic [usef_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [usef_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire usef_pkg::usef_rx_ev_t rx_ev,
    output logic rx_halt,
    input wire logic tx_load,
    input wire logic tx_last_bit,
    input wire logic tx_busy,
    output usef_pkg::usef_tx_req_t tx_req
);
    // Write and read channel holding registers.
    logic aw_held_r;
    logic w_held_r;
    logic [usef_pkg::ADDR_W-1:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    // Control and status state.
    logic [usef_pkg::CT_W-1:0] ctrl_r;
    logic [usef_pkg::DATA_W-1:0] rxbuf_r;
    logic [usef_pkg::DATA_W-1:0] txbuf_r;
    logic tx_buffer_empty_flag_r;
    logic rx_buffer_full_flag_r;
    logic fer_r;
    logic per_r;
    logic transmit_end_flag_r;
    logic rx_multiproc_bit_r;
    logic tx_multiproc_bit_r;
    logic arm_tx_buffer_empty_flag_r;
    logic arm_rx_buffer_full_flag_r;
    logic arm_fer_r;
    logic arm_per_r;

    logic wr_fire;
    logic rd_fire;
    logic [usef_pkg::ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_lane0;
    logic wr_status;
    logic wr_ctrl;
    logic wr_tx;
    logic rd_status;
    logic rd_rx;
    logic is_sync;
    logic rx_accept;
    logic frame_bad;
    logic parity_bad;
    logic [usef_pkg::DATA_W-1:0] status_val;

    assign is_sync = ctrl_r[usef_pkg::CT_SYNC];

    // The address and data may come in either order; each is parked until its partner arrives.
    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready = !w_held_r && !bvalid_r;
    assign wr_addr = aw_held_r ? awaddr_r : s_axi_awaddr;
    assign wr_data = w_held_r ? wdata_r : s_axi_wdata;
    assign wr_strb = w_held_r ? wstrb_r : s_axi_wstrb;
    assign wr_fire = (aw_held_r || (s_axi_awvalid && s_axi_awready))
        && (w_held_r || (s_axi_wvalid && s_axi_wready));
    assign wr_lane0 = wr_fire && wr_strb[0];
    assign wr_status = wr_lane0 && (wr_addr == usef_pkg::OFS_STATUS);
    assign wr_ctrl = wr_lane0 && (wr_addr == usef_pkg::OFS_CTRL);
    assign wr_tx = wr_lane0 && (wr_addr == usef_pkg::OFS_TXDATA);

    assign s_axi_arready = !rvalid_r;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign rd_status = rd_fire && (s_axi_araddr == usef_pkg::OFS_STATUS);
    assign rd_rx = rd_fire && (s_axi_araddr == usef_pkg::OFS_RXDATA);

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    always_comb begin
        status_val = '0;
        status_val[usef_pkg::ST_TX_BUFFER_EMPTY_FLAG] = tx_buffer_empty_flag_r;
        status_val[usef_pkg::ST_RX_BUFFER_FULL_FLAG] = rx_buffer_full_flag_r;
        status_val[usef_pkg::ST_FER] = fer_r;
        status_val[usef_pkg::ST_PER] = per_r;
        status_val[usef_pkg::ST_TRANSMIT_END_FLAG] = transmit_end_flag_r;
        status_val[usef_pkg::ST_RX_MULTIPROC_BIT] = rx_multiproc_bit_r;
        status_val[usef_pkg::ST_TX_MULTIPROC_BIT] = tx_multiproc_bit_r;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            aw_held_r <= 1'b0;
            awaddr_r <= '0;
        end else if (wr_fire) begin
            aw_held_r <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            w_held_r <= 1'b0;
            wdata_r <= '0;
            wstrb_r <= '0;
        end else if (wr_fire) begin
            w_held_r <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bvalid_r <= 1'b0;
            bresp_r <= usef_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r <= (wr_addr == usef_pkg::OFS_STATUS || wr_addr == usef_pkg::OFS_CTRL
                || wr_addr == usef_pkg::OFS_TXDATA) ? usef_pkg::RESP_OKAY
                : usef_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // Read data is captured at acceptance so the read side effects match the value returned.
    always_ff @(posedge clk) begin
        if (rst) begin
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= usef_pkg::RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_r <= 1'b1;
            rresp_r <= usef_pkg::RESP_OKAY;
            case (s_axi_araddr)
                usef_pkg::OFS_STATUS: begin
                    rdata_r <= {24'h000000, status_val};
                end
                usef_pkg::OFS_CTRL: begin
                    rdata_r <= {25'h0000000, ctrl_r};
                end
                usef_pkg::OFS_RXDATA: begin
                    rdata_r <= {24'h000000, rxbuf_r};
                end
                usef_pkg::OFS_TXDATA: begin
                    rdata_r <= {24'h000000, txbuf_r};
                end
                default: begin
                    rdata_r <= '0;
                    rresp_r <= usef_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_r <= usef_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_r <= wr_data[usef_pkg::CT_W-1:0];
        end
    end

    // A flag is armed when a status read returns it as one; only an armed flag clears on zero.
    always_ff @(posedge clk) begin
        if (rst) begin
            arm_tx_buffer_empty_flag_r <= 1'b0;
            arm_rx_buffer_full_flag_r <= 1'b0;
            arm_fer_r <= 1'b0;
            arm_per_r <= 1'b0;
        end else begin
            arm_tx_buffer_empty_flag_r <= rd_status ? (arm_tx_buffer_empty_flag_r || tx_buffer_empty_flag_r) : (arm_tx_buffer_empty_flag_r && tx_buffer_empty_flag_r);
            arm_rx_buffer_full_flag_r <= rd_status ? (arm_rx_buffer_full_flag_r || rx_buffer_full_flag_r) : (arm_rx_buffer_full_flag_r && rx_buffer_full_flag_r);
            arm_fer_r <= rd_status ? (arm_fer_r || fer_r) : (arm_fer_r && fer_r);
            arm_per_r <= rd_status ? (arm_per_r || per_r) : (arm_per_r && per_r);
        end
    end

    // Error flags hold reception; receive enable only gates new events, never the flags.
    assign rx_halt = fer_r || per_r;
    assign rx_accept = rx_ev.done && ctrl_r[usef_pkg::CT_RXEN] && !rx_halt;
    // The second stop bit is never delivered here, so two-stop mode tests only the first.
    assign frame_bad = rx_accept && !is_sync && !rx_ev.stop_first;
    assign parity_bad = rx_accept && !is_sync && ctrl_r[usef_pkg::CT_PAREN]
        && ((^{rx_ev.data, rx_ev.parity}) ^ ctrl_r[usef_pkg::CT_PARODD]);

    always_ff @(posedge clk) begin
        if (rst) begin
            fer_r <= 1'b0;
        end else if (frame_bad) begin
            fer_r <= 1'b1;
        end else if (wr_status && arm_fer_r && !wr_data[usef_pkg::ST_FER]) begin
            fer_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            per_r <= 1'b0;
        end else if (parity_bad) begin
            per_r <= 1'b1;
        end else if (wr_status && arm_per_r && !wr_data[usef_pkg::ST_PER]) begin
            per_r <= 1'b0;
        end
    end

    // A bad character still lands in the buffer, but the full flag is not set.
    always_ff @(posedge clk) begin
        if (rst) begin
            rxbuf_r <= '0;
        end else if (rx_accept) begin
            rxbuf_r <= rx_ev.data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rx_buffer_full_flag_r <= 1'b0;
        end else if (rx_accept && !frame_bad && !parity_bad) begin
            rx_buffer_full_flag_r <= 1'b1;
        end else if (rd_rx || (wr_status && arm_rx_buffer_full_flag_r && !wr_data[usef_pkg::ST_RX_BUFFER_FULL_FLAG])) begin
            rx_buffer_full_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rx_multiproc_bit_r <= 1'b0;
        end else if (rx_accept && !is_sync && ctrl_r[usef_pkg::CT_MPEN]) begin
            rx_multiproc_bit_r <= rx_ev.mpb;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tx_multiproc_bit_r <= 1'b0;
        end else if (wr_status) begin
            tx_multiproc_bit_r <= wr_data[usef_pkg::ST_TX_MULTIPROC_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            txbuf_r <= '0;
        end else if (wr_tx) begin
            txbuf_r <= wr_data[usef_pkg::DATA_W-1:0];
        end
    end

    // Empty sets win over any clear in the same cycle so a hand-off is never lost.
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_buffer_empty_flag_r <= usef_pkg::STATUS_RESET[usef_pkg::ST_TX_BUFFER_EMPTY_FLAG];
        end else if (!ctrl_r[usef_pkg::CT_TXEN] || tx_load) begin
            tx_buffer_empty_flag_r <= 1'b1;
        end else if (wr_tx || (wr_status && arm_tx_buffer_empty_flag_r && !wr_data[usef_pkg::ST_TX_BUFFER_EMPTY_FLAG])) begin
            tx_buffer_empty_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            transmit_end_flag_r <= usef_pkg::STATUS_RESET[usef_pkg::ST_TRANSMIT_END_FLAG];
        end else if (!ctrl_r[usef_pkg::CT_TXEN]) begin
            transmit_end_flag_r <= 1'b1;
        end else if (tx_last_bit && tx_buffer_empty_flag_r && !tx_load) begin
            transmit_end_flag_r <= 1'b1;
        end else if (wr_tx || (wr_status && arm_tx_buffer_empty_flag_r && !wr_data[usef_pkg::ST_TX_BUFFER_EMPTY_FLAG])) begin
            transmit_end_flag_r <= 1'b0;
        end
    end

    // Buffered data is offered while the empty flag is low; the halt term stops the shifter.
    always_comb begin
        tx_req.data_valid = !tx_buffer_empty_flag_r && ctrl_r[usef_pkg::CT_TXEN];
        tx_req.data = txbuf_r;
        tx_req.mpb_en = !is_sync && ctrl_r[usef_pkg::CT_MPEN] && tx_busy;
        tx_req.mpb = tx_multiproc_bit_r && tx_req.mpb_en;
        tx_req.halt = is_sync && fer_r;
    end
endmodule
`default_nettype wire

// ---- inc/usef_pkg.sv ----
// Shared constants and carrier types for the serial status flag block.
package usef_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 4;

    // Register byte offsets.
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_RXDATA = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_TXDATA = 4'hc;

    // Status register bit positions.
    localparam int ST_TX_BUFFER_EMPTY_FLAG = 7;
    localparam int ST_RX_BUFFER_FULL_FLAG = 6;
    localparam int ST_FER = 4;
    localparam int ST_PER = 3;
    localparam int ST_TRANSMIT_END_FLAG = 2;
    localparam int ST_RX_MULTIPROC_BIT = 1;
    localparam int ST_TX_MULTIPROC_BIT = 0;

    // Control register bit positions.
    localparam int CT_RXEN = 0;
    localparam int CT_TXEN = 1;
    localparam int CT_SYNC = 2;
    localparam int CT_PAREN = 3;
    localparam int CT_PARODD = 4;
    localparam int CT_TWOSTOP = 5;
    localparam int CT_MPEN = 6;
    localparam int CT_W = 7;

    localparam logic [CT_W-1:0] CTRL_RESET = 7'h00;
    localparam logic [DATA_W-1:0] STATUS_RESET = 8'h84;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // One finished character from the receive shifter.
    typedef struct packed {
        logic done;
        logic [DATA_W-1:0] data;
        logic stop_first;
        logic parity;
        logic mpb;
    } usef_rx_ev_t;

    // Transmit side hand-off towards the shifter.
    typedef struct packed {
        logic data_valid;
        logic [DATA_W-1:0] data;
        logic mpb;
        logic mpb_en;
        logic halt;
    } usef_tx_req_t;
endpackage
